/* File: test/far_channels.sv */
`timescale 1ns/10ps
module far_channels
  import uart_burst_pkg::*;
(
  input wire logic ref_clk,
  input wire logic fill,
  input wire logic [CHAN_W-1:0] fill_chan,
  input wire logic [6:0] fill_n,
  input wire logic slow,
  input wire logic [NUM_CHAN-1:0] rx_pop,
  output logic [NUM_CHAN-1:0] rx_empty,
  output logic [NUM_CHAN*BYTE_W-1:0] rx_head_data,
  output logic [NUM_CHAN*BYTE_W-1:0] rx_head_status,
  input wire logic tx_valid,
  input wire logic [CHAN_W-1:0] tx_chan,
  input wire logic [BYTE_W-1:0] tx_data,
  output logic tx_ready
);
  logic [6:0] cnt [NUM_CHAN] = '{default: 7'h00};
  logic [7:0] ptr [NUM_CHAN] = '{default: 8'h00};
  logic [2:0] tick = 3'h0;
  logic [10:0] got [$];
  // slow mode accepts one byte in eight so the tx buffer backs up
  assign tx_ready = !slow || tick == 3'h0;
  always_comb
    for (int c = 0; c < NUM_CHAN; c++) begin
      rx_empty[c] = cnt[c] == 7'h00;
      // empty head shows the inverted read pointer, which holds still while empty, never stale data
      rx_head_data[c*8+:8] = rx_empty[c] ? ~ptr[c] : ptr[c] + 8'(c * 32);
      rx_head_status[c*8+:8] = rx_head_data[c*8+:8] ^ 8'h5a;
    end
  always @(posedge ref_clk) begin
    tick <= tick + 3'h1;
    if (tx_valid && tx_ready) got.push_back({tx_chan, tx_data});
    for (int c = 0; c < NUM_CHAN; c++)
      if (fill && fill_chan == 3'(c)) begin
        cnt[c] <= fill_n;
        ptr[c] <= 8'h00;
      end else if (rx_pop[c] && cnt[c] != 7'h00) begin
        cnt[c] <= cnt[c] - 7'h01;
        ptr[c] <= ptr[c] + 8'h01;
      end
  end
endmodule

/* File: test/uart_burst_checker.sv */
`timescale 1ns/10ps
module uart_burst_checker
  import uart_burst_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [LANES-1:0] host_be,
  input wire logic host_ack,
  input wire logic [NUM_CHAN-1:0] rx_empty,
  input wire logic [NUM_CHAN-1:0] rx_pop,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [CHAN_W-1:0] tx_chan,
  input wire logic [BYTE_W-1:0] tx_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_ack;
    host_ack ##1 !host_ack;
  endsequence
  sequence s_pop;
    rx_pop != 8'h00 ##1 rx_pop == 8'h00;
  endsequence
  property p_ack_pulse; host_ack |-> s_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
  property p_ack_req; host_ack |-> host_req; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_ack_bound; host_req && !host_ack |-> ##[0:1000] host_ack; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("access never acked");
  property p_pop_full; rx_pop != 8'h00 |-> (rx_pop & rx_empty) == 8'h00; endproperty
  a_pop_full: assert property (p_pop_full) else $error("pop of empty channel");
  property p_pop_chan;
    rx_pop != 8'h00 |-> host_req && !host_we && rx_pop == (8'h01 << host_addr[11:9]);
  endproperty
  a_pop_chan: assert property (p_pop_chan) else $error("pop of wrong channel");
  property p_pop_gap; rx_pop != 8'h00 |-> s_pop; endproperty
  a_pop_gap: assert property (p_pop_gap) else $error("pops not spaced");
  property p_stat_nopop;
    host_req && !host_we && host_addr[8:7] == 2'h3 && host_be == 4'h1 |-> rx_pop == 8'h00;
  endproperty
  a_stat_nopop: assert property (p_stat_nopop) else $error("status lane popped");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_chan) && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte not held");
endmodule
bind uart_fifo_burst_data_port uart_burst_checker u_chk(.ref_clk(ref_clk), .resetn(resetn), .host_req(host_req),
  .host_we(host_we), .host_addr(host_addr), .host_be(host_be), .host_ack(host_ack), .rx_empty(rx_empty),
  .rx_pop(rx_pop), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_chan(tx_chan), .tx_data(tx_data));

/* File: test/uart_fifo_burst_data_port_tb.sv */
`timescale 1ns/10ps
module uart_fifo_burst_data_port_tb;
  import uart_burst_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, host_req = 1'b0, host_we = 1'b0, fill = 1'b0, slow = 1'b0;
  logic [11:0] host_addr = 12'h000;
  logic [3:0] host_be = 4'h0;
  logic [31:0] host_wdata = 32'h0, rd, host_rdata;
  logic [7:0] full_mask = 8'h00, rx_empty, rx_pop, tx_data;
  logic [2:0] fill_chan = 3'h0, tx_chan;
  logic [6:0] fill_n = 7'h00;
  logic [63:0] hd, hs;
  logic host_ack, tx_valid, tx_ready;
  logic [10:0] exq [$];
  int mismatches = 0, num_checks = 0;
  uart_fifo_burst_data_port u_dut(.ref_clk(ref_clk), .resetn(resetn), .host_req(host_req), .host_we(host_we),
    .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata), .host_ack(host_ack), .host_rdata(host_rdata),
    .rx_empty(rx_empty), .rx_head_data(hd), .rx_head_status(hs), .rx_pop(rx_pop), .tx_full(full_mask),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_chan(tx_chan), .tx_data(tx_data));
  far_channels u_far(.ref_clk(ref_clk), .fill(fill), .fill_chan(fill_chan), .fill_n(fill_n), .slow(slow),
    .rx_pop(rx_pop), .rx_empty(rx_empty), .rx_head_data(hd), .rx_head_status(hs), .tx_valid(tx_valid),
    .tx_chan(tx_chan), .tx_data(tx_data), .tx_ready(tx_ready));
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [7:0] ed(input int c, input int i);
    return 8'(i + c * 32);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held until the edge that sees ack; caller releases with rel
  task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd);
    int n;
    host_req <= 1'b1;
    host_we <= we;
    host_addr <= a;
    host_be <= be;
    host_wdata <= wd;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (host_ack !== 1'b1 && n < 2000);
    rd = host_rdata;
    chk(32'(n < 2000), 32'h1);
    @(posedge ref_clk);
  endtask
  task automatic rel;
    host_req <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic fillc(input logic [2:0] c, input logic [6:0] n);
    fill_chan <= c;
    fill_n <= n;
    fill <= 1'b1;
    @(posedge ref_clk);
    fill <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_plain;
    fillc(3'h2, 7'h40);
    acc(1'b0, 12'h440, 4'hf, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 12'h500 + 12'(4 * i), 4'hf, 32'h0);
      chk(rd, {ed(2, 4*i+3), ed(2, 4*i+2), ed(2, 4*i+1), ed(2, 4*i)});
    end
    acc(1'b0, 12'h53c, 4'hf, 32'h0);
    rel;
    chk(rd, {4{EMPTY_READ_BYTE}});
  endtask
  task automatic t_paired;
    fillc(3'h5, 7'h40);
    acc(1'b0, 12'hb80, 4'h1, 32'h0);
    rel;
    chk(rd[7:0], ed(5, 0) ^ 8'h5a);
    for (int i = 0; i < 32; i++) begin
      acc(1'b0, 12'hb80 + 12'(4 * i), 4'hf, 32'h0);
      chk(rd, {ed(5, 2*i+1), ed(5, 2*i+1) ^ 8'h5a, ed(5, 2*i), ed(5, 2*i) ^ 8'h5a});
    end
    rel;
    chk(rx_empty[5], 1'b1);
  endtask
  task automatic t_legacy;
    fillc(3'h7, 7'h02);
    for (int i = 0; i < 2; i++) begin
      acc(1'b0, 12'he00, 4'h1, 32'h0);
      rel;
      chk(rd[7:0], ed(7, i));
    end
  endtask
  // mid-run reset: ack, tx_valid and rx_pop must clear and read data return to RDATA_RESET
  task automatic t_reset;
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({host_ack, tx_valid, rx_pop}, 32'h0);
    chk(host_rdata, RDATA_RESET);
    @(posedge ref_clk);
    resetn <= 1'b1;
  endtask
  task automatic t_write;
    slow <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 12'h100 + 12'(c) * 12'h200, 4'hf, {ed(c, 3), ed(c, 2), ed(c, 1), ed(c, 0)});
      for (int l = 0; l < 4; l++) exq.push_back({3'(c), ed(c, l)});
    end
    acc(1'b1, 12'h730, 4'h7, 32'h00332211);
    acc(1'b1, 12'h904, 4'h3, 32'h00005544);
    acc(1'b1, 12'h180, 4'hf, 32'h66666666);
    acc(1'b1, 12'h040, 4'hf, 32'h88888888);
    rel;
    exq.push_back(11'h311);
    exq.push_back(11'h322);
    exq.push_back(11'h333);
    exq.push_back(11'h444);
    exq.push_back(11'h455);
    exq.push_back(11'h077);
    full_mask <= 8'h02;
    acc(1'b1, 12'h300, 4'hf, 32'hdeadbeef);
    acc(1'b1, 12'h000, 4'h1, 32'h00000077);
    rel;
    full_mask <= 8'h00;
    for (int n = 0; n < 2000 && u_far.got.size() < exq.size(); n++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    chk(32'(u_far.got.size()), 32'(exq.size()));
    foreach (exq[i]) chk(u_far.got[i], exq[i]);
    chk(tx_valid, 1'b0);
    slow <= 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    t_plain;
    t_paired;
    t_legacy;
    t_reset;
    t_write;
    end_of_test;
  end
endmodule

/* File: verilog/uart_burst_pkg.sv */
package uart_burst_pkg;

  localparam int NUM_CHAN = 8;
  localparam int CHAN_W = 3;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int LANES = 4;

  // per-channel layout: channel N owns a 0x200 slice starting at N*0x200
  localparam logic [ADDR_W-1:0] CHAN_STRIDE = 12'h200;
  localparam int CHAN_LSB = 9;
  localparam logic [8:0] LEGACY_OFS = 9'h000;
  localparam logic [8:0] DATA_WIN_OFS = 9'h100;
  localparam logic [8:0] DATA_WIN_LAST = 9'h13f;
  localparam logic [8:0] STAT_WIN_OFS = 9'h180;
  localparam logic [8:0] STAT_WIN_LAST = 9'h1ff;

  localparam int RX_FIFO_BYTES = 64;
  localparam int TX_BUF_DEPTH = 32;
  localparam int TX_BUF_WIDTH = CHAN_W + BYTE_W;

  // value returned for bytes read past the end of the receive data
  localparam logic [BYTE_W-1:0] EMPTY_READ_BYTE = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    REGION_NONE,
    REGION_LEGACY,
    REGION_DATA,
    REGION_STAT
  } region_t;

endpackage

/* File: verilog/uart_fifo_burst_data_port.sv */
`timescale 1ns/10ps
// What this block does
// - decode 64-byte data window per channel
// - decode status-paired read window per channel
// - full receive FIFO readable in 16 dwords
// - plain read: oldest byte in lane 0
// - paired read: status, data, status, data
// - paired window drains FIFO in 32 dwords
// - transmit write enqueues lane 0 first
// - transmit windows at 0x100 plus 0x200 steps
// - 8 to 32 bit accesses, byte per lane
// - burst accesses up to 64 bytes accepted
// - legacy byte holding register per channel
// - one oscillator clock drives all logic

module tx_byte_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  // pointers wrap by compare, so depth need not be a power of two
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] ptr);
    if (ptr == PTR_W'(DEPTH - 1)) begin
      bump = '0;
    end else begin
      bump = ptr + 1'b1;
    end
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [PTR_W:0] count;
  logic [PTR_W:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != (PTR_W+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = bump(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = bump(rd_ptr);
    end
    case ({push, pop})
      2'b10: next_count = count + 1'b1;
      2'b01: next_count = count - 1'b1;
      default: next_count = count;
    endcase
  end

  // storage itself needs no reset; pointers and count do
  always_ff @(posedge ref_clk) begin
    mem <= next_mem;
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule

module uart_fifo_burst_data_port
  import uart_burst_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [LANES-1:0] host_be,
  input wire logic [31:0] host_wdata,
  output logic host_ack,
  output logic [31:0] host_rdata,
  input wire logic [NUM_CHAN-1:0] rx_empty,
  input wire logic [NUM_CHAN*BYTE_W-1:0] rx_head_data,
  input wire logic [NUM_CHAN*BYTE_W-1:0] rx_head_status,
  output logic [NUM_CHAN-1:0] rx_pop,
  input wire logic [NUM_CHAN-1:0] tx_full,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [CHAN_W-1:0] tx_chan,
  output logic [BYTE_W-1:0] tx_data
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LANE,
    ST_POP_WAIT,
    ST_DONE
  } state_t;

  function automatic logic in_window(input logic [8:0] ofs,
                                     input logic [8:0] lo,
                                     input logic [8:0] hi);
    in_window = (ofs >= lo) && (ofs <= hi);
  endfunction

  function automatic region_t decode_region(input logic [ADDR_W-1:0] addr);
    logic [8:0] ofs;
    ofs = addr[8:0];
    if (ofs[8:2] == LEGACY_OFS[8:2]) begin
      decode_region = REGION_LEGACY;
    end else if (in_window(ofs, DATA_WIN_OFS, DATA_WIN_LAST)) begin
      decode_region = REGION_DATA;
    end else if (in_window(ofs, STAT_WIN_OFS, STAT_WIN_LAST)) begin
      decode_region = REGION_STAT;
    end else begin
      decode_region = REGION_NONE;
    end
  endfunction

  function automatic logic [BYTE_W-1:0] pick_byte(input logic [NUM_CHAN*BYTE_W-1:0] bus,
                                                  input logic [CHAN_W-1:0] chan);
    pick_byte = bus[chan*BYTE_W +: BYTE_W];
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] word,
                                           input logic [1:0] lane_sel,
                                           input logic [BYTE_W-1:0] value);
    logic [31:0] merged;
    merged = word;
    merged[lane_sel*BYTE_W +: BYTE_W] = value;
    put_byte = merged;
  endfunction

  function automatic logic [BYTE_W-1:0] get_lane(input logic [31:0] word,
                                                 input logic [1:0] lane_sel);
    get_lane = word[lane_sel*BYTE_W +: BYTE_W];
  endfunction

  // all state below runs on the single oscillator-derived clock
  state_t state, next_state;
  logic [1:0] lane;
  logic [1:0] next_lane;
  logic req_we;
  logic next_req_we;
  region_t req_region;
  region_t next_req_region;
  logic [CHAN_W-1:0] req_chan;
  logic [CHAN_W-1:0] next_req_chan;
  logic [LANES-1:0] req_be;
  logic [LANES-1:0] next_req_be;
  logic [31:0] req_wdata;
  logic [31:0] next_req_wdata;
  logic [31:0] next_host_rdata;
  logic next_host_ack;
  logic [NUM_CHAN-1:0] next_rx_pop;
  logic next_tx_valid;
  logic [CHAN_W-1:0] next_tx_chan;
  logic [BYTE_W-1:0] next_tx_data;

  logic buf_in_valid;
  logic buf_in_ready;
  logic [TX_BUF_WIDTH-1:0] buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [TX_BUF_WIDTH-1:0] buf_out_data;

  logic lane_on;
  logic advance;
  logic [BYTE_W-1:0] wr_byte;

  tx_byte_fifo #(
    .WIDTH(TX_BUF_WIDTH),
    .DEPTH(TX_BUF_DEPTH)
  ) tx_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // legacy holding register is byte wide: only lane 0 counts
  assign lane_on = req_be[lane] && (req_region != REGION_LEGACY || lane == 2'd0);
  assign wr_byte = get_lane(req_wdata, lane);
  assign buf_in_data = {req_chan, wr_byte};

  always_comb begin
    next_state = state;
    next_lane = lane;
    next_req_we = req_we;
    next_req_region = req_region;
    next_req_chan = req_chan;
    next_req_be = req_be;
    next_req_wdata = req_wdata;
    next_host_rdata = host_rdata;
    next_host_ack = 1'b0;
    next_rx_pop = '0;
    buf_in_valid = 1'b0;
    advance = 1'b0;
    case (state)
      ST_IDLE: begin
        // each beat of a burst is simply the next request
        if (host_req && !host_ack) begin
          next_state = ST_LANE;
          next_lane = 2'd0;
          next_req_we = host_we;
          next_req_region = decode_region(host_addr);
          next_req_chan = host_addr[CHAN_LSB +: CHAN_W];
          next_req_be = host_be;
          next_req_wdata = host_wdata;
          next_host_rdata = RDATA_RESET;
        end
      end
      ST_LANE: begin
        // lanes walk 0..3 so the lowest enabled lane gets the oldest byte
        if (!lane_on || req_region == REGION_NONE) begin
          advance = 1'b1;
        end else if (req_we) begin
          if (req_region == REGION_STAT) begin
            advance = 1'b1;
          end else if (tx_full[req_chan]) begin
            advance = 1'b1;
          end else if (buf_in_ready) begin
            buf_in_valid = 1'b1;
            advance = 1'b1;
          end
          // buffer full: hold the lane and stall the host
        end else if (req_region == REGION_STAT && !lane[0]) begin
          // status lane reports the head entry but leaves it queued
          next_host_rdata = put_byte(next_host_rdata, lane,
            rx_empty[req_chan] ? EMPTY_READ_BYTE : pick_byte(rx_head_status, req_chan));
          advance = 1'b1;
        end else if (rx_empty[req_chan]) begin
          next_host_rdata = put_byte(next_host_rdata, lane, EMPTY_READ_BYTE);
          advance = 1'b1;
        end else begin
          next_host_rdata = put_byte(next_host_rdata, lane, pick_byte(rx_head_data, req_chan));
          next_rx_pop[req_chan] = 1'b1;
          next_state = ST_POP_WAIT;
        end
      end
      ST_POP_WAIT: begin
        // one spare cycle lets the channel present its new head
        advance = 1'b1;
      end
      ST_DONE: begin
        next_host_ack = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (advance) begin
      if (lane == 2'd3) begin
        next_state = ST_DONE;
      end else begin
        next_state = ST_LANE;
        next_lane = lane + 1'b1;
      end
    end
  end

  // output stage keeps transmit outputs straight from flops
  always_comb begin
    buf_out_ready = !tx_valid || tx_ready;
    next_tx_valid = tx_valid;
    next_tx_chan = tx_chan;
    next_tx_data = tx_data;
    if (buf_out_ready) begin
      next_tx_valid = buf_out_valid;
      if (buf_out_valid) begin
        next_tx_chan = buf_out_data[TX_BUF_WIDTH-1 -: CHAN_W];
        next_tx_data = buf_out_data[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      lane <= 2'd0;
      req_we <= 1'b0;
      req_region <= REGION_NONE;
      req_chan <= '0;
      req_be <= '0;
      req_wdata <= '0;
      host_rdata <= RDATA_RESET;
      host_ack <= 1'b0;
      rx_pop <= '0;
    end else begin
      state <= next_state;
      lane <= next_lane;
      req_we <= next_req_we;
      req_region <= next_req_region;
      req_chan <= next_req_chan;
      req_be <= next_req_be;
      req_wdata <= next_req_wdata;
      host_rdata <= next_host_rdata;
      host_ack <= next_host_ack;
      rx_pop <= next_rx_pop;
    end
  end

  // separate tx flops: a stalled host never blocks draining
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_chan <= '0;
      tx_data <= '0;
    end else begin
      tx_valid <= next_tx_valid;
      tx_chan <= next_tx_chan;
      tx_data <= next_tx_data;
    end
  end

endmodule
